// ### hw/tprs_pkg.sv
// types shared by the tone pair receive steering block
package tprs_pkg;

  typedef enum logic [2:0] {
    STEER_IDLE,
    STEER_QUALIFY,
    STEER_SETTLE,
    STEER_HELD
  } tprs_steer_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } tprs_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } tprs_axi_rsp_t;

  typedef struct packed {
    logic       toneOe;
    logic       irqOut;
    logic       irqOe;
    logic       guardOut;
    logic       guardOe;
    logic       hostBusOe;
    logic       earlyToneDetect;
  } tprs_pins_t;

  typedef struct packed {
    logic [2:0]  lowSync;
    logic [2:0]  highSync;
    logic [1:0]  pdSync;
    logic [15:0] lowCnt;
    logic [15:0] highCnt;
    logic        lowValid;
    logic        highValid;
    logic [1:0]  lowIdx;
    logic [1:0]  highIdx;
    logic        early_tone_detect;
    tprs_steer_t steer;
    logic [23:0] guardCnt;
    logic        guard;
    logic        delayedSteering;
    logic [3:0]  pendCode;
    logic [3:0]  rxData;
    logic        rxDataValid;
    logic        irqPend;
    logic [2:0]  ctrl;
    logic        awHeld;
    logic [7:0]  awAddr;
    logic        wHeld;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } tprs_state_t;

endpackage

// ### hw/tprs_receive_steering.sv
// tone pair receive steering core with axi4-lite registers
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`include "tprs_regs.svh"

module tprs_receive_steering #(
  parameter logic [23:0] GTP_CYC    = 24'(`TPRS_GTP_CYC),
  parameter logic [23:0] GTA_CYC    = 24'(`TPRS_GTA_CYC),
  parameter logic [23:0] SETTLE_CYC = 24'(`TPRS_SETTLE_CYC)
) (
  input  wire logic                    clock,
  input  wire logic                    sys_rst,
  input  wire tprs_pkg::tprs_axi_req_t axiReq,
  output tprs_pkg::tprs_axi_rsp_t      axiRsp,
  input  wire logic                    lowToneSquare,
  input  wire logic                    highToneSquare,
  input  wire logic                    chipPowerDownPin,
  output tprs_pkg::tprs_pins_t         pins
);

  // band limits in cycles, one oscillator clock for all timing
  localparam int CLK_HZ = `TPRS_CLK_HZ;
  localparam int TOL    = `TPRS_TOL_PERMIL;
  localparam int LOW_HZ  [4] = '{697, 770, 852, 941};
  localparam int HIGH_HZ [4] = '{1209, 1336, 1477, 1633};
  localparam logic [15:0] LOW_LOSS  =
    16'(CLK_HZ / `TPRS_LOW_LOSS_HZ);
  localparam logic [15:0] HIGH_LOSS =
    16'(CLK_HZ / `TPRS_HIGH_LOSS_HZ);

  tprs_pkg::tprs_state_t cur;
  tprs_pkg::tprs_state_t nxt;

  logic fullPd;
  logic rxPd;
  logic txPd;
  logic lowEdge;
  logic highEdge;
  logic lowHit;
  logic highHit;
  logic [1:0] lowBand;
  logic [1:0] highBand;
  logic wrFire;
  logic rdFire;
  logic dsRise;
  logic statusRead;

  // period counting: a period matches when inside the tolerance band
  function automatic logic [2:0] classify(input logic [15:0] per,
                                          input logic        hiGrp);
    logic [2:0] res;
    int         nom;
    res = 3'h0;
    for (int i = 0; i < 4; i++) begin
      nom = CLK_HZ / (hiGrp ? HIGH_HZ[i] : LOW_HZ[i]);
      if (int'(per) * 1000 >= nom * (1000 - TOL) &&
          int'(per) * 1000 <= nom * (1000 + TOL)) begin
        res = {1'b1, 2'(i)};
      end
    end
    return res;
  endfunction

  // row is the low tone, column the high tone
  function automatic logic [3:0] encode(input logic [1:0] row,
                                        input logic [1:0] col);
    logic [3:0] code;
    code = 4'h0;
    if (col == 2'h3) begin
      code = (row == 2'h3) ? 4'h0 : 4'(4'hD + {2'h0, row});
    end else if (row == 2'h3) begin
      unique case (col)
        2'h0:    code = 4'hB;
        2'h1:    code = 4'hA;
        default: code = 4'hC;
      endcase
    end else begin
      code = 4'(row * 2'h3 + {2'h0, col} + 4'h1);
    end
    return code;
  endfunction

  always_comb begin
    nxt = cur;

    // power-down pin wins over the register bits
    fullPd = cur.pdSync[1] |
             (cur.ctrl[`TPRS_CTRL_RXPD] & cur.ctrl[`TPRS_CTRL_TXDIS]);
    rxPd   = fullPd | cur.ctrl[`TPRS_CTRL_RXPD];
    txPd   = fullPd | cur.ctrl[`TPRS_CTRL_TXDIS];

    nxt.lowSync  = {cur.lowSync[1:0], lowToneSquare};
    nxt.highSync = {cur.highSync[1:0], highToneSquare};
    nxt.pdSync   = {cur.pdSync[0], chipPowerDownPin};
    lowEdge  = cur.lowSync[1] & ~cur.lowSync[2];
    highEdge = cur.highSync[1] & ~cur.highSync[2];
    {lowHit, lowBand}   = classify(cur.lowCnt, 1'b0);
    {highHit, highBand} = classify(cur.highCnt, 1'b1);

    // low group period meter; silence past the loss limit drops it
    if (lowEdge) begin
      nxt.lowCnt   = 16'h0000;
      nxt.lowValid = lowHit;
      nxt.lowIdx   = lowBand;
    end else if (cur.lowCnt >= LOW_LOSS) begin
      nxt.lowValid = 1'b0;
    end else begin
      nxt.lowCnt = cur.lowCnt + 16'h0001;
    end

    if (highEdge) begin
      nxt.highCnt   = 16'h0000;
      nxt.highValid = highHit;
      nxt.highIdx   = highBand;
    end else if (cur.highCnt >= HIGH_LOSS) begin
      nxt.highValid = 1'b0;
    end else begin
      nxt.highCnt = cur.highCnt + 16'h0001;
    end

    // early detect follows the pair condition with no hold-over
    nxt.early_tone_detect = nxt.lowValid & nxt.highValid & ~rxPd;

    // steering: the rc network is replaced by guard counters
    dsRise = 1'b0;
    unique case (cur.steer)
      tprs_pkg::STEER_IDLE: begin
        nxt.guardCnt = 24'h00_0000;
        if (cur.early_tone_detect) begin
          nxt.steer    = tprs_pkg::STEER_QUALIFY;
          nxt.guardCnt = 24'h00_0001;
        end
      end
      tprs_pkg::STEER_QUALIFY: begin
        if (!cur.early_tone_detect) begin
          // too short to count as a tone
          nxt.steer = tprs_pkg::STEER_IDLE;
        end else if (cur.guardCnt >= GTP_CYC) begin
          nxt.pendCode = encode(cur.lowIdx, cur.highIdx);
          nxt.steer    = tprs_pkg::STEER_SETTLE;
          nxt.guardCnt = 24'h00_0000;
        end else begin
          nxt.guardCnt = cur.guardCnt + 24'h00_0001;
        end
      end
      tprs_pkg::STEER_SETTLE: begin
        // the pair is already registered; only the latch settles
        if (cur.guardCnt + 24'h00_0001 >= SETTLE_CYC) begin
          nxt.steer           = tprs_pkg::STEER_HELD;
          nxt.guardCnt        = 24'h00_0000;
          nxt.delayedSteering = 1'b1;
          dsRise              = 1'b1;
        end else begin
          nxt.guardCnt = cur.guardCnt + 24'h00_0001;
        end
      end
      tprs_pkg::STEER_HELD: begin
        if (cur.early_tone_detect) begin
          // a dropout shorter than the pause guard is forgiven
          nxt.guardCnt = 24'h00_0000;
        end else if (cur.guardCnt + 24'h00_0001 >= GTA_CYC) begin
          nxt.steer           = tprs_pkg::STEER_IDLE;
          nxt.delayedSteering = 1'b0;
          nxt.guardCnt        = 24'h00_0000;
        end else begin
          nxt.guardCnt = cur.guardCnt + 24'h00_0001;
        end
      end
      default: nxt.steer = tprs_pkg::STEER_IDLE;
    endcase

    // latch moves only on the steering rise, never earlier
    if (dsRise) begin
      nxt.rxData = cur.pendCode;
    end

    nxt.guard = (nxt.steer == tprs_pkg::STEER_SETTLE ||
                 nxt.steer == tprs_pkg::STEER_HELD) & nxt.early_tone_detect;

    // axi4-lite write: address and data taken in either order
    if (axiReq.awvalid && !cur.awHeld) begin
      nxt.awHeld = 1'b1;
      nxt.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && !cur.wHeld) begin
      nxt.wHeld = 1'b1;
      nxt.wData = axiReq.wdata;
      nxt.wStrb = axiReq.wstrb;
    end
    wrFire = cur.awHeld & cur.wHeld & ~cur.bvalid;
    if (wrFire) begin
      nxt.awHeld = 1'b0;
      nxt.wHeld  = 1'b0;
      nxt.bvalid = 1'b1;
      nxt.bresp  = 2'h0;
      unique case (cur.awAddr)
        `TPRS_OFS_CTRL: begin
          if (cur.wStrb[0]) begin
            nxt.ctrl = cur.wData[2:0];
          end
        end
        `TPRS_OFS_STATUS, `TPRS_OFS_RXDATA: ;
        default: nxt.bresp = 2'h2;
      endcase
    end
    if (cur.bvalid && axiReq.bready) begin
      nxt.bvalid = 1'b0;
    end

    // axi4-lite read: one cycle from address to data
    rdFire     = axiReq.arvalid & ~cur.rvalid;
    statusRead = 1'b0;
    if (rdFire) begin
      nxt.rvalid = 1'b1;
      nxt.rresp  = 2'h0;
      nxt.rdata  = 32'h0000_0000;
      unique case (axiReq.araddr)
        `TPRS_OFS_CTRL: nxt.rdata[2:0] = cur.ctrl;
        `TPRS_OFS_STATUS: begin
          statusRead = 1'b1;
          nxt.rdata[`TPRS_STAT_EST]    = cur.early_tone_detect;
          nxt.rdata[`TPRS_STAT_GUARD]  = cur.guard;
          nxt.rdata[`TPRS_STAT_VALID]  = cur.rxDataValid;
          nxt.rdata[`TPRS_STAT_DSTEER] = cur.delayedSteering;
        end
        `TPRS_OFS_RXDATA: nxt.rdata[3:0] = cur.rxData;
        default: nxt.rresp = 2'h2;
      endcase
    end else if (cur.rvalid && axiReq.rready) begin
      nxt.rvalid = 1'b0;
    end

    // clear first so a rise in the same cycle still sets
    if (statusRead) begin
      nxt.rxDataValid = 1'b0;
      nxt.irqPend     = 1'b0;
    end
    if (dsRise) begin
      nxt.rxDataValid = 1'b1;
      nxt.irqPend     = 1'b1;
    end

    // tone detection, steering and pending irq state is held cleared while powered down; rxData and rxDataValid keep their values
    if (rxPd) begin
      nxt.lowValid        = 1'b0;
      nxt.highValid       = 1'b0;
      nxt.lowCnt          = 16'h0000;
      nxt.highCnt         = 16'h0000;
      nxt.early_tone_detect             = 1'b0;
      nxt.steer           = tprs_pkg::STEER_IDLE;
      nxt.guardCnt        = 24'h00_0000;
      nxt.guard           = 1'b0;
      nxt.delayedSteering = 1'b0;
      nxt.irqPend         = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cur      <= '0;
      cur.ctrl <= `TPRS_CTRL_RESET;
    end else begin
      cur <= nxt;
    end
  end

  assign axiRsp.awready = ~cur.awHeld;
  assign axiRsp.wready  = ~cur.wHeld;
  assign axiRsp.bvalid  = cur.bvalid;
  assign axiRsp.bresp   = cur.bresp;
  assign axiRsp.arready = ~cur.rvalid;
  assign axiRsp.rvalid  = cur.rvalid;
  assign axiRsp.rdata   = cur.rdata;
  assign axiRsp.rresp   = cur.rresp;

  // open-drain interrupt only ever pulls low
  assign pins.irqOut          = 1'b0;
  assign pins.irqOe           = cur.ctrl[`TPRS_CTRL_IRQMODE] & cur.irqPend &
                                cur.delayedSteering & ~fullPd;
  assign pins.toneOe          = ~txPd;
  assign pins.guardOut        = cur.guard;
  assign pins.guardOe         = ~rxPd;
  assign pins.hostBusOe       = ~fullPd;
  assign pins.earlyToneDetect = cur.early_tone_detect;

endmodule // tprs_receive_steering

// ### hw/tprs_regs.svh
// register map, field positions and timing counts of the tone pair receiver
`ifndef TPRS_REGS_SVH
`define TPRS_REGS_SVH

`define TPRS_CLK_HZ        10_000_000
`define TPRS_OSC_XTAL_HZ   3_579_545

`define TPRS_OFS_CTRL      8'h00
`define TPRS_OFS_STATUS    8'h04
`define TPRS_OFS_RXDATA    8'h08

`define TPRS_CTRL_RXPD     0
`define TPRS_CTRL_TXDIS    1
`define TPRS_CTRL_IRQMODE  2
`define TPRS_STAT_EST      0
`define TPRS_STAT_GUARD    1
`define TPRS_STAT_VALID    2
`define TPRS_STAT_DSTEER   3

`define TPRS_CTRL_RESET    3'h0

`define TPRS_GTP_US        40
`define TPRS_GTA_US        40
`define TPRS_SETTLE_NS     1000
`define TPRS_GTP_CYC   ((`TPRS_GTP_US * (`TPRS_CLK_HZ / 1_000_000)))
`define TPRS_GTA_CYC   ((`TPRS_GTA_US * (`TPRS_CLK_HZ / 1_000_000)))
`define TPRS_SETTLE_CYC ((`TPRS_SETTLE_NS * (`TPRS_CLK_HZ / 1_000_000)) / 1000)

`define TPRS_TOL_PERMIL    15
`define TPRS_LOW_LOSS_HZ   680
`define TPRS_HIGH_LOSS_HZ  1190

`endif

// ### tb/tprs_receive_steering_assertions.sv
// port-level checks for the tone pair receive steering block
`timescale 1ns/10ps
module tprs_receive_steering_assertions #(
  parameter logic [23:0] GTP_CYC    = 24'h00_0014,
  parameter logic [23:0] GTA_CYC    = 24'h00_0014,
  parameter logic [23:0] SETTLE_CYC = 24'h00_0002
) (
  input wire logic                    clock,
  input wire logic                    sys_rst,
  input wire tprs_pkg::tprs_axi_req_t axiReq,
  input wire tprs_pkg::tprs_axi_rsp_t axiRsp,
  input wire logic                    lowToneSquare,
  input wire logic                    highToneSquare,
  input wire logic                    chipPowerDownPin,
  input wire tprs_pkg::tprs_pins_t    pins
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  logic [23:0] estRun_q;

  // length of the current unbroken early detect run
  always_ff @(posedge clock) begin
    if (sys_rst || !pins.earlyToneDetect) estRun_q <= 24'h00_0000;
    else estRun_q <= estRun_q + 24'h00_0001;
  end

  a_guard_gtp : assert property (
    $rose(pins.guardOut) |-> estRun_q >= GTP_CYC)
    else $error("guard drive rose before present guard time");
  a_guard_est : assert property (
    $rose(pins.guardOut) |-> pins.earlyToneDetect)
    else $error("guard drive rose without early detect");
  a_guard_drop : assert property (
    $fell(pins.guardOut) && pins.guardOe && !chipPowerDownPin
      |-> !pins.earlyToneDetect)
    else $error("guard drive fell while early detect high");
  a_flag_settle : assert property (
    $rose(pins.guardOut) |-> !pins.irqOe [*2])
    else $error("flag rose without settling delay");
  a_irq_clear : assert property (
    axiReq.arvalid && axiRsp.arready && axiReq.araddr == 8'h04
      |-> ##[1:2] !pins.irqOe)
    else $error("status read left interrupt active");
  a_read_next : assert property (
    axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
    else $error("read answer late");
  a_read_clear : assert property (
    axiRsp.rvalid && axiReq.rready |=> !axiRsp.rvalid)
    else $error("read answer not retired");
  a_ready_low : assert property (axiRsp.rvalid |-> !axiRsp.arready)
    else $error("read address accepted while answer pending");
  a_unmapped_err : assert property (
    axiReq.arvalid && axiRsp.arready && axiReq.araddr > 8'h08
      |=> axiRsp.rresp == 2'h2)
    else $error("unmapped read not refused");
  a_full_pd : assert property (
    chipPowerDownPin [*4]
      |-> !pins.hostBusOe && !pins.toneOe && !pins.irqOe)
    else $error("pins driven in full power down");

  c_irq : cover property ($rose(pins.irqOe));
  c_est : cover property ($rose(pins.earlyToneDetect));
  c_guard_end : cover property ($fell(pins.guardOut));
endmodule  // tprs_receive_steering_assertions

// ### tb/tprs_receive_steering_tb_top.sv
// testbench top: register sequences against the tone pair receiver
`timescale 1ns/10ps
module tprs_receive_steering_tb_top;
  localparam logic [23:0] GTA = 24'h00_0014;

  logic                    clock;
  logic                    sys_rst;
  logic                    chipPowerDownPin;
  logic                    toneOn;
  logic                    lowToneSquare;
  logic                    highToneSquare;
  tprs_pkg::tprs_axi_req_t axiReq;
  tprs_pkg::tprs_axi_rsp_t axiRsp;
  tprs_pkg::tprs_pins_t    pins;
  int                      mismatches;
  int                      num_checks;
  logic [31:0]             rdVal;
  logic [1:0]              rdResp;

  tprs_receive_steering #(.GTP_CYC(24'h00_0014), .GTA_CYC(GTA),
    .SETTLE_CYC(24'h00_0002)) dut (
    .clock(clock), .sys_rst(sys_rst), .axiReq(axiReq), .axiRsp(axiRsp),
    .lowToneSquare(lowToneSquare), .highToneSquare(highToneSquare),
    .chipPowerDownPin(chipPowerDownPin), .pins(pins));

  // 941 Hz and 1209 Hz at the 10 MHz clock
  tprs_tone_source #(.LOW_HALF(5313), .HIGH_HALF(4135)) src (
    .clock(clock), .toneOn(toneOn), .lowToneSquare(lowToneSquare),
    .highToneSquare(highToneSquare));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic timeout(input string what);
    mismatches++;
    $display("CHECK FAILED %s expected answer seen timeout", what);
    finish_test();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr <= a;
    axiReq.wvalid <= 1'b1;
    axiReq.wdata <= d;
    axiReq.wstrb <= 4'hf;
    axiReq.bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clock);
      if (axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiRsp.wready) axiReq.wvalid <= 1'b0;
      if (axiRsp.bvalid) break;
    end
    axiReq.bready <= 1'b0;
    if (n == 100) timeout("write");
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge clock);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr <= a;
    axiReq.rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clock);
      if (axiRsp.arready) axiReq.arvalid <= 1'b0;
      if (axiRsp.rvalid) break;
    end
    rdVal = axiRsp.rdata;
    rdResp = axiRsp.rresp;
    axiReq.rready <= 1'b0;
    if (n == 100) timeout("read");
  endtask

  // tone detection takes whole periods, hence the long bound
  task automatic waitFor(input logic sel, input logic lvl);
    int n;
    for (n = 0; n < 60000; n++) begin
      @(posedge clock);
      if ((sel ? pins.irqOe : pins.earlyToneDetect) === lvl) break;
    end
    if (n == 60000) timeout("pin wait");
  endtask

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  initial begin
    sys_rst = 1'b1;
    chipPowerDownPin = 1'b0;
    toneOn = 1'b0;
    axiReq = '0;
    mismatches = 0;
    num_checks = 0;
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    check("toneOe", 32'(pins.toneOe), 32'h0000_0001);
    check("irqOut", 32'(pins.irqOut), 32'h0000_0000);
    rd(8'h00);
    check("ctrl", rdVal, 32'h0000_0000);
    rd(8'h0c);
    check("resp", 32'(rdResp), 32'h0000_0002);
    wr(8'h00, 32'h0000_0004);
    toneOn <= 1'b1;
    waitFor(1'b0, 1'b1);
    rd(8'h08);
    check("rxdata", rdVal, 32'h0000_0000);
    waitFor(1'b1, 1'b1);
    check("guard", 32'(pins.guardOut), 32'h0000_0001);
    rd(8'h08);
    check("rxdata", rdVal, 32'h0000_000b);
    rd(8'h04);
    check("status", rdVal, 32'h0000_000f);
    repeat (2) @(posedge clock);
    check("irq", 32'(pins.irqOe), 32'h0000_0000);
    rd(8'h04);
    check("status", rdVal, 32'h0000_000b);
    toneOn <= 1'b0;
    waitFor(1'b0, 1'b0);
    repeat (GTA + 5) @(posedge clock);
    rd(8'h04);
    check("status", rdVal, 32'h0000_0000);
    rd(8'h08);
    check("rxdata", rdVal, 32'h0000_000b);
    wr(8'h00, 32'h0000_0002);
    repeat (2) @(posedge clock);
    check("toneOe", 32'(pins.toneOe), 32'h0000_0000);
    check("busOe", 32'(pins.hostBusOe), 32'h0000_0001);
    wr(8'h00, 32'h0000_0003);
    repeat (2) @(posedge clock);
    check("busOe", 32'(pins.hostBusOe), 32'h0000_0000);
    check("guardOe", 32'(pins.guardOe), 32'h0000_0000);
    check("toneOe", 32'(pins.toneOe), 32'h0000_0000);
    check("irqOe", 32'(pins.irqOe), 32'h0000_0000);
    wr(8'h00, 32'h0000_0000);
    chipPowerDownPin <= 1'b1;
    repeat (5) @(posedge clock);
    check("busOe", 32'(pins.hostBusOe), 32'h0000_0000);
    check("toneOe", 32'(pins.toneOe), 32'h0000_0000);
    finish_test();
  end
endmodule  // tprs_receive_steering_tb_top

bind tprs_receive_steering tprs_receive_steering_assertions #(
  .GTP_CYC(GTP_CYC), .GTA_CYC(GTA_CYC), .SETTLE_CYC(SETTLE_CYC)
) checker_i (
  .clock(clock), .sys_rst(sys_rst), .axiReq(axiReq), .axiRsp(axiRsp),
  .lowToneSquare(lowToneSquare), .highToneSquare(highToneSquare),
  .chipPowerDownPin(chipPowerDownPin), .pins(pins));

// ### tb/tprs_tone_source.sv
// square wave source standing in for the two tone comparators
`timescale 1ns/10ps
module tprs_tone_source #(
  parameter int LOW_HALF  = 5313,
  parameter int HIGH_HALF = 4135
) (
  input  wire logic clock,
  input  wire logic toneOn,
  output logic      lowToneSquare,
  output logic      highToneSquare
);
  int lowCnt;
  int highCnt;

  initial begin
    lowToneSquare = 1'b0;
    highToneSquare = 1'b0;
    lowCnt = 0;
    highCnt = 0;
  end

  // comparators sit low with no signal present
  always @(posedge clock) begin
    if (!toneOn) begin
      lowCnt <= 0;
      highCnt <= 0;
      lowToneSquare <= 1'b0;
      highToneSquare <= 1'b0;
    end else begin
      lowCnt <= (lowCnt == LOW_HALF - 1) ? 0 : lowCnt + 1;
      highCnt <= (highCnt == HIGH_HALF - 1) ? 0 : highCnt + 1;
      if (lowCnt == LOW_HALF - 1) lowToneSquare <= ~lowToneSquare;
      if (highCnt == HIGH_HALF - 1) highToneSquare <= ~highToneSquare;
    end
  end
endmodule  // tprs_tone_source
